//--- rtl/epl_index_latch.sv
`timescale 1ns/10ps
module epl_index_latch import epl_pkg::*; #(
  parameter int ST_BITS = 12,
  parameter int MT_BITS = 8,
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int PAUSE_CYC = SSI_PAUSE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Encoder pins
  input wire logic index_pin,
  input wire logic enc_data_pin,
  output logic enc_clk,
  // Status
  output logic index_event
);

  if (ST_BITS < 2 || ST_BITS > 31 || MT_BITS < 1 || ST_BITS + MT_BITS > 64) begin : g_bad
    $error("epl_index_latch: unsupported frame widths");
  end

  epl_core_if #(.ST_BITS(ST_BITS), .MT_BITS(MT_BITS)) core_if ();

  logic [31:0] encoder_config;
  logic [31:0] step_resolution_config;
  logic [31:0] internal_actual_position;
  logic [31:0] internal_position_capture;
  logic [31:0] external_position_counter;
  logic [31:0] index_reload_value;
  logic [31:0] external_position_capture;
  logic [31:0] encoder_resolution;
  logic [CONST_BITS-1:0] scale_const;

  logic idx_meta;
  logic idx_sync;
  logic idx_prev;
  logic idx_edge;
  logic qualify;
  logic do_clear;
  logic do_latch_ext;
  logic do_latch_int;
  logic wr_cfg;
  logic wr_step;
  logic wr_res;
  logic div_pending;

  logic [ST_BITS-1:0] prev_angle;
  logic signed [31:0] turn_count;
  logic signed [31:0] next_turn_count;
  logic signed [63:0] next_turns;
  logic signed [63:0] next_count;
  logic signed [63:0] next_prod;
  logic [30:0] half_res;
  logic [30:0] angle_ext;
  logic [30:0] prev_ext;
  logic [8:0] mstep;
  logic [11:0] fullsteps;
  logic [20:0] steps_per_rev;

  ////////////////////////////////////////////////////////////////////////////
  // Sub blocks
  epl_ssi_rx #(.HALF_CYC(HALF_CYC), .PAUSE_CYC(PAUSE_CYC)) u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .enc_data_pin(enc_data_pin),
    .enc_clk(enc_clk),
    .c(core_if.rx)
  );

  epl_const_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .d(core_if.div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Index synchroniser and event qualification
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idx_meta <= 1'b0;
      idx_sync <= 1'b0;
      idx_prev <= 1'b0;
    end else begin
      idx_meta <= index_pin;
      idx_sync <= idx_meta;
      idx_prev <= idx_sync;
    end
  end

  always_comb begin
    idx_edge = idx_sync & ~idx_prev;
    qualify = idx_edge & (encoder_config[CFG_CONTINUOUS] | encoder_config[CFG_ONCE_ARM]);
    do_clear = qualify & encoder_config[CFG_CLEAR_ON_INDEX];
    do_latch_ext = qualify & encoder_config[CFG_LATCH_EXT];
    do_latch_int = do_latch_ext & encoder_config[CFG_LATCH_INT];
    wr_cfg = reg_wr && reg_addr == ADDR_ENC_CFG;
    wr_step = reg_wr && reg_addr == ADDR_STEP_CFG;
    wr_res = reg_wr && reg_addr == ADDR_RES_CONST;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_event <= 1'b0;
    end else begin
      index_event <= qualify;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register, one-shot arm cleared after use
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      encoder_config <= ENC_CFG_RST;
    end else if (wr_cfg) begin
      encoder_config <= reg_wdata;
    end else if (qualify && !encoder_config[CFG_CONTINUOUS]) begin
      encoder_config[CFG_ONCE_ARM] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain software registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      step_resolution_config <= STEP_CFG_RST;
      encoder_resolution <= RES_RST;
      index_reload_value <= POS_RST;
      internal_actual_position <= POS_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_STEP_CFG: step_resolution_config <= reg_wdata;
        ADDR_RES_CONST: encoder_resolution <= reg_wdata;
        ADDR_RELOAD_CAP: index_reload_value <= reg_wdata;
        ADDR_INT_POS: internal_actual_position <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture registers take values before any reload
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      external_position_capture <= POS_RST;
      internal_position_capture <= POS_RST;
    end else begin
      if (do_latch_ext) begin
        external_position_capture <= external_position_counter;
      end
      if (do_latch_int) begin
        internal_position_capture <= internal_actual_position;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling constant: computed or entered manually
  always_comb begin
    mstep = (step_resolution_config[STEP_MSTEP_LSB +: 4] > 4'h8) ? 9'h001 :
            9'(9'h100 >> step_resolution_config[STEP_MSTEP_LSB +: 4]);
    fullsteps = step_resolution_config[STEP_FS_LSB +: 12];
    steps_per_rev = 21'(mstep) * 21'(fullsteps);
    core_if.dividend = {11'h000, steps_per_rev, 16'h0000};
    core_if.divisor = encoder_resolution[CONST_BITS-1:0];
    core_if.req_enable = encoder_config[CFG_SERIAL_EN];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_pending <= 1'b1;
      core_if.div_start <= 1'b0;
    end else begin
      core_if.div_start <= div_pending && !encoder_resolution[RES_MANUAL_BIT];
      div_pending <= wr_step | wr_res;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scale_const <= '0;
    end else if (encoder_resolution[RES_MANUAL_BIT]) begin
      scale_const <= encoder_resolution[CONST_BITS-1:0];
    end else if (core_if.div_done) begin
      scale_const <= core_if.quotient;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Revolution handling and angle conversion
  always_comb begin
    half_res = {1'b0, encoder_resolution[30:1]};
    angle_ext = 31'(core_if.angle);
    prev_ext = 31'(prev_angle);
    next_turn_count = turn_count;
    if (prev_ext > angle_ext && (prev_ext - angle_ext) > half_res) begin
      next_turn_count = turn_count + 32'sd1;
    end else if (angle_ext > prev_ext && (angle_ext - prev_ext) > half_res) begin
      next_turn_count = turn_count - 32'sd1;
    end
    if (encoder_config[CFG_MT_EN]) begin
      if (encoder_config[CFG_MT_SIGNED]) begin
        next_turns = 64'($signed(core_if.turns));
      end else begin
        next_turns = $signed(64'(core_if.turns));
      end
    end else if (encoder_config[CFG_CALC_TURNS]) begin
      next_turns = 64'(next_turn_count);
    end else begin
      next_turns = 64'sd0;
    end
    next_count = next_turns * $signed({33'h0, encoder_resolution[30:0]}) + $signed({33'h0, angle_ext});
    next_prod = next_count * $signed({33'h0, scale_const});
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_angle <= '0;
      turn_count <= 32'sd0;
    end else if (core_if.frame_valid) begin
      prev_angle <= core_if.angle;
      turn_count <= next_turn_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External position counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      external_position_counter <= POS_RST;
    end else if (do_clear) begin
      external_position_counter <= index_reload_value;
    end else if (core_if.frame_valid) begin
      external_position_counter <= next_prod[CONST_FRAC_BITS +: 32];
    end else if (reg_wr && reg_addr == ADDR_EXT_POS) begin
      external_position_counter <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_ENC_CFG: reg_rdata <= encoder_config;
          ADDR_STEP_CFG: reg_rdata <= step_resolution_config;
          ADDR_INT_POS: reg_rdata <= internal_actual_position;
          ADDR_INT_CAP: reg_rdata <= internal_position_capture;
          ADDR_EXT_POS: reg_rdata <= external_position_counter;
          ADDR_RELOAD_CAP: reg_rdata <= external_position_capture;
          ADDR_RES_CONST: reg_rdata <= {1'b0, scale_const};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule : epl_index_latch

//--- rtl/epl_pkg.sv
package epl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [6:0] ADDR_ENC_CFG = 7'h07;
  localparam logic [6:0] ADDR_STEP_CFG = 7'h0a;
  localparam logic [6:0] ADDR_INT_POS = 7'h21;
  localparam logic [6:0] ADDR_INT_CAP = 7'h36;
  localparam logic [6:0] ADDR_EXT_POS = 7'h50;
  localparam logic [6:0] ADDR_RELOAD_CAP = 7'h51;
  localparam logic [6:0] ADDR_RES_CONST = 7'h54;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of encoder_config
  localparam int CFG_CLEAR_ON_INDEX = 0;
  localparam int CFG_CONTINUOUS = 1;
  localparam int CFG_ONCE_ARM = 2;
  localparam int CFG_LATCH_EXT = 3;
  localparam int CFG_LATCH_INT = 4;
  localparam int CFG_MT_EN = 5;
  localparam int CFG_MT_SIGNED = 6;
  localparam int CFG_CALC_TURNS = 7;
  localparam int CFG_SERIAL_EN = 8;

  // Field positions of step_resolution_config and resolution register
  localparam int STEP_MSTEP_LSB = 0;
  localparam int STEP_FS_LSB = 4;
  localparam int RES_MANUAL_BIT = 31;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] ENC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] STEP_CFG_RST = 32'h0000_0c80;
  localparam logic [31:0] RES_RST = 32'h0000_1000;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  // Scaling constant format
  localparam int CONST_INT_BITS = 15;
  localparam int CONST_FRAC_BITS = 16;
  localparam int CONST_BITS = CONST_INT_BITS + CONST_FRAC_BITS;
  localparam int DIV_BITS = 48;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 60;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int SSI_PAUSE_NS = 21000;
  localparam int SSI_PAUSE_CYC = (SSI_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {RX_PAUSE, RX_START, RX_HIGH, RX_LOW} epl_rx_state_t;

endpackage : epl_pkg

//--- rtl/epl_core_if.sv
`timescale 1ns/10ps
interface epl_core_if #(
  parameter int ST_BITS = 12,
  parameter int MT_BITS = 8
);
  import epl_pkg::*;
  // Serial frame
  logic req_enable;
  logic frame_valid;
  logic [ST_BITS-1:0] angle;
  logic [MT_BITS-1:0] turns;
  // Constant divider
  logic div_start;
  logic [DIV_BITS-1:0] dividend;
  logic [CONST_BITS-1:0] divisor;
  logic [CONST_BITS-1:0] quotient;
  logic div_done;

  modport rx (input req_enable, output frame_valid, angle, turns);
  modport div (input div_start, dividend, divisor, output quotient, div_done);
  modport core (output req_enable, div_start, dividend, divisor,
                input frame_valid, angle, turns, quotient, div_done);
endinterface : epl_core_if

//--- rtl/epl_ssi_rx.sv
`timescale 1ns/10ps
module epl_ssi_rx import epl_pkg::*; #(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int PAUSE_CYC = SSI_PAUSE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Encoder pins
  input wire logic enc_data_pin,
  output logic enc_clk,
  // Core side
  epl_core_if.rx c
);
  localparam int NBITS = $bits(c.angle) + $bits(c.turns);
  localparam int CW = $clog2(PAUSE_CYC + HALF_CYC + 1);

  if (HALF_CYC < 1 || PAUSE_CYC < 1) begin : g_bad
    $error("epl_ssi_rx: timing counts must be at least one");
  end

  epl_rx_state_t state;
  logic [CW-1:0] tmr;
  logic [7:0] bits_left;
  logic [NBITS-1:0] shreg;
  logic data_meta;
  logic data_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser
  always_ff @(posedge clock) begin
    data_meta <= enc_data_pin;
    data_sync <= data_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation and shifting, sample on falling edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= RX_PAUSE;
      tmr <= '0;
      bits_left <= '0;
      shreg <= '0;
      enc_clk <= 1'b1;
      c.frame_valid <= 1'b0;
      c.angle <= '0;
      c.turns <= '0;
    end else begin
      c.frame_valid <= 1'b0;
      case (state)
        RX_PAUSE: begin
          enc_clk <= 1'b1;
          if (tmr < CW'(PAUSE_CYC - 1)) begin
            tmr <= tmr + 1'b1;
          end else if (c.req_enable) begin
            tmr <= '0;
            enc_clk <= 1'b0;
            bits_left <= 8'(NBITS);
            state <= RX_START;
          end
        end
        RX_START, RX_LOW: begin
          if (tmr < CW'(HALF_CYC - 1)) begin
            tmr <= tmr + 1'b1;
          end else if (bits_left == '0) begin
            tmr <= '0;
            enc_clk <= 1'b1;
            c.angle <= shreg[$bits(c.angle)-1:0];
            c.turns <= shreg[NBITS-1:$bits(c.angle)];
            c.frame_valid <= 1'b1;
            state <= RX_PAUSE;
          end else begin
            tmr <= '0;
            enc_clk <= 1'b1;
            state <= RX_HIGH;
          end
        end
        RX_HIGH: begin
          if (tmr < CW'(HALF_CYC - 1)) begin
            tmr <= tmr + 1'b1;
          end else begin
            tmr <= '0;
            enc_clk <= 1'b0;
            shreg <= {shreg[NBITS-2:0], data_sync};
            bits_left <= bits_left - 1'b1;
            state <= RX_LOW;
          end
        end
        default: state <= RX_PAUSE;
      endcase
    end
  end

endmodule : epl_ssi_rx

//--- rtl/epl_const_div.sv
`timescale 1ns/10ps
module epl_const_div import epl_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Core side
  epl_core_if.div d
);
  logic busy;
  logic [5:0] cnt;
  logic [CONST_BITS-1:0] rem;
  logic [CONST_BITS-1:0] dvs;
  logic [DIV_BITS-1:0] quo;
  logic [CONST_BITS:0] next_sh;
  logic next_fit;
  logic [DIV_BITS-1:0] next_quo;

  ////////////////////////////////////////////////////////////////////////////
  // Restoring division step
  always_comb begin
    next_sh = {rem, quo[DIV_BITS-1]};
    next_fit = next_sh >= {1'b0, dvs};
    next_quo = {quo[DIV_BITS-2:0], next_fit};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= '0;
      rem <= '0;
      dvs <= '0;
      quo <= '0;
      d.quotient <= '0;
      d.div_done <= 1'b0;
    end else begin
      d.div_done <= 1'b0;
      if (d.div_start) begin
        busy <= 1'b1;
        cnt <= 6'(DIV_BITS);
        rem <= '0;
        dvs <= d.divisor;
        quo <= d.dividend;
      end else if (busy) begin
        rem <= next_fit ? CONST_BITS'(next_sh - {1'b0, dvs}) : next_sh[CONST_BITS-1:0];
        quo <= next_quo;
        cnt <= cnt - 1'b1;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          d.div_done <= 1'b1;
          d.quotient <= (|next_quo[DIV_BITS-1:CONST_BITS]) ? '1 : next_quo[CONST_BITS-1:0];
        end
      end
    end
  end

endmodule : epl_const_div

//--- test/epl_ssi_enc_model.sv
`timescale 1ns/10ps
module epl_ssi_enc_model #(
  parameter int BITS = 20
) (
  // Link
  input wire logic enc_clk,
  output logic data_out,
  // Word reported per frame
  input wire logic [BITS-1:0] word
);
  logic [BITS-1:0] shreg;
  int cnt;
  initial begin
    data_out = 1'b0;
    shreg = '0;
    cnt = BITS + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Idle fall starts a frame with one whole word
  always @(negedge enc_clk) begin
    if (cnt == BITS + 1) begin
      shreg = word;
      cnt = 0;
    end
  end
  // Bits change on rising edges, MSB first; released line inverts
  always @(posedge enc_clk) begin
    if (cnt < BITS) begin
      data_out = shreg[BITS-1];
      shreg = shreg << 1;
      cnt = cnt + 1;
    end else if (cnt == BITS) begin
      data_out = ~data_out;
      cnt = BITS + 1;
    end
  end
endmodule : epl_ssi_enc_model

//--- test/epl_index_latch_properties.sv
`timescale 1ns/10ps
module epl_index_latch_chk import epl_pkg::*; #(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Encoder pins
  input wire logic index_pin,
  input wire logic enc_data_pin,
  input wire logic enc_clk,
  // Status
  input wire logic index_event
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  int lo_cnt;
  int hi_cnt;
  logic mapped;
  ////////////////////////////////////////////////////////////////////////////
  // Serial clock phase lengths
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= enc_clk ? 0 : lo_cnt + 1;
      hi_cnt <= enc_clk ? hi_cnt + 1 : 0;
    end
  end
  assign mapped = reg_addr inside {ADDR_ENC_CFG, ADDR_STEP_CFG, ADDR_INT_POS, ADDR_INT_CAP,
                                   ADDR_EXT_POS, ADDR_RELOAD_CAP, ADDR_RES_CONST};
  ////////////////////////////////////////////////////////////////////////////
  a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_manual_const: assert property (reg_wr && reg_addr == ADDR_RES_CONST && reg_wdata[31] ##2
      reg_rd && reg_addr == ADDR_RES_CONST |=> reg_rdata == {1'b0, $past(reg_wdata, 3) & 32'h7fff_ffff})
    else $error("manual constant not read back");
  a_clk_idle_high: assert property ($rose(rst_n) |-> enc_clk)
    else $error("serial clock not idle after reset");
  a_clk_low_width: assert property ($rose(enc_clk) |-> lo_cnt == HALF_CYC)
    else $error("serial clock low phase wrong");
  a_clk_high_width: assert property ($fell(enc_clk) |-> hi_cnt >= HALF_CYC)
    else $error("serial clock high phase short");
  a_event_single: assert property (index_event |=> !index_event)
    else $error("index event longer than one cycle");
  a_event_cause: assert property (index_event |-> $past(index_pin, 2))
    else $error("index event without index pin");
  c_event: cover property (index_event);
  c_frame: cover property ($rose(enc_clk));
  c_read: cover property (reg_rvalid);
endmodule : epl_index_latch_chk

bind epl_index_latch epl_index_latch_chk #(.HALF_CYC(HALF_CYC)) chk_u (.clock(clock), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .index_pin(index_pin), .enc_data_pin(enc_data_pin), .enc_clk(enc_clk),
  .index_event(index_event));

//--- test/epl_index_latch_tb_top.sv
`timescale 1ns/10ps
module epl_index_latch_tb_top import epl_pkg::*;;
  logic clock, rst_n, reg_wr, reg_rd, index_pin, enc_data_pin, enc_clk, reg_rvalid, index_event;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, p1;
  logic [19:0] enc_word;
  int miscompares = 0;
  int n_compared = 0;
  int n_events = 0;
  epl_index_latch #(.HALF_CYC(6), .PAUSE_CYC(20)) dut_u (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .index_pin(index_pin), .enc_data_pin(enc_data_pin), .enc_clk(enc_clk),
    .index_event(index_event));
  epl_ssi_enc_model #(.BITS(20)) enc_u (.enc_clk(enc_clk), .data_out(enc_data_pin), .word(enc_word));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (index_event === 1'b1) n_events <= n_events + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clock);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic rdchk(input logic [6:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask : rdchk
  task automatic poll(input logic [6:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    for (int i = 0; i < 500; i++) begin
      rd(a, d);
      if (d === exp) break;
    end
    check(what, d, exp);
    if (d !== exp) results();
  endtask : poll
  task automatic pulse_index();
    @(posedge clock);
    #1 index_pin = 1'b1;
    repeat (6) @(posedge clock);
    #1 index_pin = 1'b0;
    repeat (6) @(posedge clock);
  endtask : pulse_index
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    results();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, index_pin, reg_addr, reg_wdata} = '0;
    enc_word = 20'h0_0000;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    // Reset values and register access
    rdchk(ADDR_ENC_CFG, ENC_CFG_RST, "cfg");
    rdchk(ADDR_STEP_CFG, STEP_CFG_RST, "step");
    wr(ADDR_INT_CAP, 32'h0000_dead);
    rdchk(ADDR_INT_CAP, 32'h0000_0000, "int_cap_ro");
    rdchk(7'h7f, 32'h0000_0000, "unmapped");
    poll(ADDR_RES_CONST, 32'h000c_8000, "const_dflt");
    wr(ADDR_RES_CONST, 32'h0000_03e8);
    poll(ADDR_RES_CONST, 32'h0033_3333, "const_frac");
    wr(ADDR_STEP_CFG, 32'h0000_0c81);
    wr(ADDR_RES_CONST, 32'h0000_1000);
    poll(ADDR_RES_CONST, 32'h0006_4000, "const_mstep");
    wr(ADDR_STEP_CFG, 32'h0000_0c80);
    poll(ADDR_RES_CONST, 32'h000c_8000, "const_back");
    wr(ADDR_RES_CONST, 32'h8000_1234);
    rdchk(ADDR_RES_CONST, 32'h0000_1234, "const_manual");
    wr(ADDR_RES_CONST, 32'h0000_1000);
    poll(ADDR_RES_CONST, 32'h000c_8000, "const_auto");
    // Serial angles to microsteps
    enc_word = {8'h02, 12'h100};
    wr(ADDR_ENC_CFG, 32'h0000_0100);
    poll(ADDR_EXT_POS, 32'h0000_0c80, "pos_st");
    wr(ADDR_ENC_CFG, 32'h0000_0120);
    poll(ADDR_EXT_POS, 32'h0001_9c80, "pos_mt");
    enc_word = {8'hfe, 12'h100};
    poll(ADDR_EXT_POS, 32'h00c6_7c80, "pos_unsigned");
    wr(ADDR_ENC_CFG, 32'h0000_0160);
    poll(ADDR_EXT_POS, 32'hfffe_7c80, "pos_signed");
    enc_word = {8'h00, 12'hf00};
    wr(ADDR_ENC_CFG, 32'h0000_0180);
    repeat (700) @(posedge clock);
    rd(ADDR_EXT_POS, p1);
    enc_word = {8'h00, 12'h100};
    poll(ADDR_EXT_POS, p1 + 32'h0000_1900, "pos_wrap");
    wr(ADDR_ENC_CFG, 32'h0000_0000);
    repeat (400) @(posedge clock);
    // Continuous clear and latch
    wr(ADDR_EXT_POS, 32'h0000_1234);
    wr(ADDR_RELOAD_CAP, 32'h0000_0abc);
    wr(ADDR_INT_POS, 32'h0000_5555);
    wr(ADDR_ENC_CFG, 32'h0000_001b);
    pulse_index();
    rdchk(ADDR_EXT_POS, 32'h0000_0abc, "reload");
    rdchk(ADDR_RELOAD_CAP, 32'h0000_1234, "ext_cap");
    rdchk(ADDR_INT_CAP, 32'h0000_5555, "int_cap");
    wr(ADDR_EXT_POS, 32'h0000_0077);
    wr(ADDR_INT_POS, 32'h0000_0066);
    pulse_index();
    rdchk(ADDR_EXT_POS, 32'h0000_0abc, "reload2");
    rdchk(ADDR_RELOAD_CAP, 32'h0000_0077, "ext_cap2");
    rdchk(ADDR_INT_CAP, 32'h0000_0066, "int_cap2");
    check("events", n_events, 32'h0000_0002);
    // One-shot clear and latch
    wr(ADDR_ENC_CFG, 32'h0000_000d);
    wr(ADDR_EXT_POS, 32'h0000_0099);
    pulse_index();
    rdchk(ADDR_EXT_POS, 32'h0000_0abc, "once_reload");
    rdchk(ADDR_RELOAD_CAP, 32'h0000_0099, "once_cap");
    rdchk(ADDR_ENC_CFG, 32'h0000_0009, "arm_cleared");
    wr(ADDR_EXT_POS, 32'h0000_0042);
    pulse_index();
    rdchk(ADDR_EXT_POS, 32'h0000_0042, "once_noclr");
    rdchk(ADDR_RELOAD_CAP, 32'h0000_0099, "once_nolatch");
    check("events_once", n_events, 32'h0000_0003);
    // Internal latch needs external latch
    wr(ADDR_INT_POS, 32'h0000_0011);
    wr(ADDR_ENC_CFG, 32'h0000_0012);
    pulse_index();
    rdchk(ADDR_INT_CAP, 32'h0000_0066, "int_cap_gated");
    // Second reset
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    rdchk(ADDR_ENC_CFG, ENC_CFG_RST, "cfg_rst2");
    rdchk(ADDR_EXT_POS, POS_RST, "pos_rst2");
    results();
  end
endmodule : epl_index_latch_tb_top
